/* include/fspc_pkg.sv */
package fspc_pkg;
  // Control register location in data space and the I/O window base.
  localparam logic [7:0] SELF_PROGRAM_CONTROL_STATUS_DATA_OFS = 8'h57;
  localparam logic [7:0] IO_BASE_OFS = 8'h20;
  localparam logic [7:0] SELF_PROGRAM_CONTROL_STATUS_IO_OFS = SELF_PROGRAM_CONTROL_STATUS_DATA_OFS - IO_BASE_OFS;
  localparam logic [7:0] SELF_PROGRAM_CONTROL_STATUS_RESET = 8'h00;
  // Control register bit positions.
  localparam int BIT_IE = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_SIGNATURE_READ_BIT = 5;
  localparam int BIT_REEN = 4;
  localparam int BIT_LOCK = 3;
  localparam int BIT_PGWR = 2;
  localparam int BIT_PGER = 1;
  localparam int BIT_STEN = 0;
  // Accepted low-five-bit command patterns.
  localparam logic [4:0] PAT_REEN = 5'h11;
  localparam logic [4:0] PAT_LOCK = 5'h09;
  localparam logic [4:0] PAT_PGWR = 5'h05;
  localparam logic [4:0] PAT_PGER = 5'h03;
  localparam logic [4:0] PAT_FILL = 5'h01;
  // Flash geometry.
  localparam int PC_W = 13;
  localparam int WORD_W = 6;
  localparam int PAGE_W = PC_W - WORD_W;
  localparam int PAGE_WORDS = 64;
  localparam logic [PAGE_W-1:0] RWW_PAGES = 7'h70;
  localparam logic [PC_W-1:0] RWW_LAST = 13'h1bff;
  localparam int Z_PAGE_LO = 7;
  localparam int Z_PAGE_HI = 13;
  localparam int Z_WORD_LO = 1;
  localparam int Z_WORD_HI = 6;
  // Boot section start for each boot size fuse code; the section ends at BOOT_END.
  localparam logic [PC_W-1:0] BOOT_START_128 = 13'h1f80;
  localparam logic [PC_W-1:0] BOOT_START_256 = 13'h1f00;
  localparam logic [PC_W-1:0] BOOT_START_512 = 13'h1e00;
  localparam logic [PC_W-1:0] BOOT_START_1K = 13'h1c00;
  localparam logic [PC_W-1:0] BOOT_END = 13'h1fff;
  // Command windows in processor clock cycles.
  localparam logic [2:0] WIN_SPM = 3'h4;
  localparam logic [2:0] WIN_LPM = 3'h3;
  // Programming time: least 3.2 ms, clock 10 MHz.
  localparam int PROG_MIN_US = 3200;
  localparam int CLK_MHZ = 10;
  localparam int PROG_CYCLES = PROG_MIN_US * CLK_MHZ;
  localparam int TMR_W = 16;
  // Sequencer states, Gray coded along idle, armed, programming.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_PROG = 2'h3
  } fspc_state_e;
endpackage : fspc_pkg

/* design/fspc_pbuf.sv */
`timescale 1ns/100ps
`default_nettype none
module fspc_pbuf #(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int DW = 16
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  // Fill port and discard.
  input wire logic wr,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [DW-1:0] wr_data,
  input wire logic clr,
  // Registered read port.
  input wire logic [AW-1:0] rd_idx,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];
  logic [DEPTH-1:0] valid_reg;
  wire [DW-1:0] rd_word = valid_reg[rd_idx] ? mem[rd_idx] : {DW{1'b1}};

  // Word storage; unloaded words read back as erased.
  always_ff @(posedge clk) begin
    if (en && wr) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Per-word valid bits, cleared together when the buffer is discarded.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      valid_reg <= '0;
      rd_data <= '0;
    end else if (en) begin
      rd_data <= rd_word;
      if (clr) begin
        valid_reg <= '0;
      end else if (wr) begin
        valid_reg[wr_idx] <= 1'b1;
      end
    end
  end
endmodule : fspc_pbuf
`default_nettype wire

/* design/fspc_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module fspc_timer #(
  parameter int W = 16,
  parameter logic [W-1:0] CYCLES = 16'h7d00
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  // Start pulse in, one-cycle done pulse out.
  input wire logic start,
  output logic done
);
  logic [W-1:0] cnt_reg;
  logic run_reg;
  wire last = run_reg && (cnt_reg == CYCLES - 1'b1);

  // Counts the programming time from the start pulse.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done <= 1'b0;
    end else if (en) begin
      done <= last;
      if (start) begin
        cnt_reg <= '0;
        run_reg <= 1'b1;
      end else if (last) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule : fspc_timer
`default_nettype wire

/* design/fspc_ctrl.sv */
// Contract
// - Boot size fuses pick 128/256/512/1024-word boot section ending at 0x1FFF.
// - Pages below 0x1C00 are read-while-write; the top 16 pages are not.
// - Program counter is 13 bits; 64-word pages use six word bits.
// - Erase and write take the page from pointer bits 13 to 7.
// - Buffer fill takes the word from pointer bits 6 to 1.
// - Pointer bits 15 and 14 ignored; bit 0 is load byte select.
// - Control register at data 0x57 or I/O 0x37, resets to zero.
// - Ready interrupt requested while enabled, global enable set, store enable low.
// - Erase or write to the shared region sets busy and blocks it.
// - Busy clears on re-enable command or when a buffer fill starts.
// - Signature read: load returns signature byte, store does nothing.
// - Re-enable store reopens the region; refused while programming runs.
// - Re-enable written during buffer loading discards the buffer.
// - Lock-set store programs lock bits from the low data byte.
// - Load after lock-set returns lock or fuse bits by pointer bit 0.
// - Page write store writes the buffer into the addressed page.
// - Page erase store erases the addressed page.
// - Erase or write in the other region halts the core throughout.
// - Store enable alone: store puts the data pair into the buffer word.
// - Store allowed for four cycles; enable held during erase or write.
// - Only five low-five-bit patterns are accepted; others do nothing.
// - Each erase, write or lock programming lasts 3.2 to 3.4 ms.
`timescale 1ns/100ps
`default_nettype none
module fspc_ctrl import fspc_pkg::*; #(
  parameter int PROG_CNT = PROG_CYCLES
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Core register access.
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_space,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Core program-memory store and load.
  input wire logic spm_req,
  input wire logic lpm_req,
  input wire logic [15:0] z_ptr,
  input wire logic [15:0] data_pair,
  input wire logic global_ie,
  output logic lpm_hit,
  output logic [7:0] lpm_data,
  output logic cpu_halt,
  output logic ready_irq,
  // Nonvolatile cells read back.
  input wire logic [1:0] boot_size_fuse,
  input wire logic [7:0] lock_bits,
  input wire logic [7:0] fuse_bits,
  input wire logic [7:0] sig_byte,
  // Flash array commands.
  output logic section_busy,
  output logic [PC_W-1:0] boot_start,
  output logic erase_go,
  output logic write_go,
  output logic lock_go,
  output logic [PAGE_W-1:0] page_addr,
  output logic [7:0] lock_data,
  input wire logic [WORD_W-1:0] pb_rd_idx,
  output logic [15:0] pb_rd_data
);
  fspc_state_e state_reg, state_next;
  logic [5:0] cmd_reg, cmd_next;
  logic ie_reg;
  logic busy_reg;
  logic [2:0] win_reg;
  logic loading_reg;
  logic tmr_done;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.

  // Either address space reaches the control register.
  wire addr_hit = (!io_space && io_addr == SELF_PROGRAM_CONTROL_STATUS_DATA_OFS) || (io_space && io_addr == SELF_PROGRAM_CONTROL_STATUS_IO_OFS);
  wire reg_wr = io_wr && addr_hit;
  wire [4:0] low5 = io_wdata[4:0];
  wire pat_ok = low5 == PAT_REEN || low5 == PAT_LOCK || low5 == PAT_PGWR ||
                low5 == PAT_PGER || low5 == PAT_FILL;
  // Commands are taken only outside programming, so re-enable is refused then.
  wire cmd_wr = reg_wr && pat_ok && state_reg != ST_PROG;
  wire sig_ok = low5 == PAT_FILL;
  wire [7:0] status_w = {ie_reg, busy_reg, cmd_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Command window and store decode.

  // Window counts down from the cycle after the write.
  wire armed = state_reg == ST_ARMED;
  wire spm_ok = armed && win_reg != 3'h0 && spm_req;
  wire lpm_ok = armed && win_reg > (WIN_SPM - WIN_LPM) && lpm_req;
  wire expire = armed && win_reg == 3'h1 && !spm_req;
  wire is_er = cmd_reg[BIT_PGER];
  wire is_wr = cmd_reg[BIT_PGWR];
  wire is_lock = cmd_reg[BIT_LOCK];
  wire is_reen = cmd_reg[BIT_REEN];
  wire is_sig = cmd_reg[BIT_SIGNATURE_READ_BIT];
  wire is_fill = cmd_reg[5:1] == 5'h00;
  // Page field is pointer bits 13..7; bits 15..14 never looked at.
  wire [PAGE_W-1:0] z_page = z_ptr[Z_PAGE_HI:Z_PAGE_LO];
  wire [WORD_W-1:0] z_word = z_ptr[Z_WORD_HI:Z_WORD_LO];
  wire page_rww = z_page < RWW_PAGES;
  wire go_pg = spm_ok && (is_er || is_wr);
  wire go_prog = go_pg || (spm_ok && is_lock);
  wire buf_fill = spm_ok && is_fill;
  // Re-enable written while words are loaded throws the buffer away.
  wire buf_drop = (cmd_wr && low5 == PAT_REEN && loading_reg) || (tmr_done && is_wr);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state.

  // Chooses the next state and command bits.
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_wr) begin
          state_next = ST_ARMED;
          cmd_next = {io_wdata[BIT_SIGNATURE_READ_BIT] && sig_ok, low5};
        end
      end
      ST_ARMED: begin
        if (cmd_wr) begin
          cmd_next = {io_wdata[BIT_SIGNATURE_READ_BIT] && sig_ok, low5};
        end else if (go_prog) begin
          state_next = ST_PROG;
        end else if (spm_ok || expire) begin
          state_next = ST_IDLE;
          cmd_next = '0;
        end
      end
      ST_PROG: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
          cmd_next = '0;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cmd_next = '0;
      end
    endcase
  end

  // State, command bits and window counter.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      cmd_reg <= SELF_PROGRAM_CONTROL_STATUS_RESET[5:0];
      win_reg <= 3'h0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      if (cmd_wr) begin
        win_reg <= WIN_SPM;
      end else if (win_reg != 3'h0) begin
        win_reg <= win_reg - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable, busy flag and halt.

  // Enable bit follows any write to the register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ie_reg <= SELF_PROGRAM_CONTROL_STATUS_RESET[BIT_IE];
    end else if (clk_en && reg_wr) begin
      ie_reg <= io_wdata[BIT_IE];
    end
  end

  // Busy is set by programming the shared region; the set wins over a clear.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= SELF_PROGRAM_CONTROL_STATUS_RESET[BIT_BUSY];
    end else if (clk_en) begin
      if (go_pg && page_rww) begin
        busy_reg <= 1'b1;
      end else if (buf_fill || (spm_ok && is_reen)) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Core stays halted for the whole operation on the upper region.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_halt <= 1'b0;
    end else if (clk_en) begin
      if (go_pg && !page_rww) begin
        cpu_halt <= 1'b1;
      end else if (tmr_done) begin
        cpu_halt <= 1'b0;
      end
    end
  end

  // Buffer holds loaded words until discarded.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loading_reg <= 1'b0;
    end else if (clk_en) begin
      if (buf_fill) begin
        loading_reg <= 1'b1;
      end else if (buf_drop) begin
        loading_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to core and flash array.

  // Boot section start from the size fuses.
  wire [PC_W-1:0] boot_w = boot_size_fuse == 2'h3 ? BOOT_START_128 :
                           boot_size_fuse == 2'h2 ? BOOT_START_256 :
                           boot_size_fuse == 2'h1 ? BOOT_START_512 : BOOT_START_1K;
  // Special loads return the signature byte, or lock or fuse bytes by pointer bit 0.
  wire [7:0] lpm_w = is_sig ? sig_byte : (z_ptr[0] ? fuse_bits : lock_bits);
  wire lpm_special = lpm_ok && (is_sig || is_lock);

  // Registered answers to the core and commands to the array.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= 8'h00;
      lpm_hit <= 1'b0;
      lpm_data <= 8'h00;
      ready_irq <= 1'b0;
      section_busy <= 1'b0;
      boot_start <= BOOT_START_1K;
      erase_go <= 1'b0;
      write_go <= 1'b0;
      lock_go <= 1'b0;
      page_addr <= '0;
      lock_data <= 8'hff;
    end else if (clk_en) begin
      if (io_rd && addr_hit) begin
        io_rdata <= status_w;
      end
      lpm_hit <= lpm_special;
      if (lpm_special) begin
        lpm_data <= lpm_w;
      end
      ready_irq <= ie_reg && global_ie && !cmd_reg[BIT_STEN];
      section_busy <= busy_reg;
      boot_start <= boot_w;
      erase_go <= spm_ok && is_er;
      write_go <= spm_ok && is_wr;
      lock_go <= spm_ok && is_lock;
      if (go_pg) begin
        page_addr <= z_page;
      end
      if (spm_ok && is_lock) begin
        lock_data <= data_pair[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temporary page buffer and programming timer.

  fspc_pbuf #(.DEPTH(PAGE_WORDS), .AW(WORD_W), .DW(16)) u_pbuf (
    .clk(clk),
    .rst_b(rst_b),
    .en(clk_en),
    .wr(buf_fill),
    .wr_idx(z_word),
    .wr_data(data_pair),
    .clr(buf_drop),
    .rd_idx(pb_rd_idx),
    .rd_data(pb_rd_data)
  );

  fspc_timer #(.W(TMR_W), .CYCLES(TMR_W'(PROG_CNT))) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .en(clk_en),
    .start(go_prog),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_read;
    io_rd && addr_hit && clk_en |=> io_rdata == $past(status_w);
  endproperty
  a_read: assert property (p_read) else $error("Control register readback wrong.");

  property p_irq;
    clk_en && ie_reg && global_ie && !cmd_reg[BIT_STEN] |=> ready_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Ready interrupt not raised.");

  property p_busy_set;
    clk_en && go_pg && page_rww |=> busy_reg ##0 !cpu_halt;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("Busy flag not set on shared region.");

  property p_busy_clr;
    clk_en && buf_fill |=> !busy_reg && loading_reg;
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("Busy flag not cleared by fill.");

  property p_halt;
    clk_en && go_pg && !page_rww |=> cpu_halt && state_reg == ST_PROG;
  endproperty
  a_halt: assert property (p_halt) else $error("Core not halted for upper region.");

  property p_expire;
    clk_en && expire && !reg_wr |=> state_reg == ST_IDLE && cmd_reg == 6'h00;
  endproperty
  a_expire: assert property (p_expire) else $error("Window did not expire.");

  property p_window;
    clk_en && cmd_wr ##1 (clk_en && !cmd_wr) [*4] |=> win_reg == 3'h0;
  endproperty
  a_window: assert property (p_window) else $error("Store window not four cycles.");

  property p_bad_pat;
    clk_en && reg_wr && !pat_ok && !armed && !tmr_done |=> $stable(cmd_reg) && $stable(state_reg);
  endproperty
  a_bad_pat: assert property (p_bad_pat) else $error("Illegal pattern took effect.");

  property p_hold;
    state_reg == ST_PROG |-> cmd_reg[BIT_STEN];
  endproperty
  a_hold: assert property (p_hold) else $error("Store enable dropped during programming.");

  property p_drop;
    clk_en && buf_drop |=> !loading_reg;
  endproperty
  a_drop: assert property (p_drop) else $error("Buffer not discarded.");

  c_erase: cover property (clk_en && spm_ok && is_er);
  c_write_no_read_while_write_region: cover property (clk_en && go_pg && !page_rww);
  c_fill: cover property (clk_en && buf_fill);
  c_lock_read: cover property (clk_en && lpm_special && is_lock);
endmodule : fspc_ctrl
`default_nettype wire

/* tb/fspc_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Behavioural processor core: register strobes and store or load instructions, one at a time.
module fspc_core_model (
  // Clock.
  input wire logic clk,
  // Register access.
  output logic io_wr,
  output logic io_rd,
  output logic io_space,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Program-memory instructions.
  output logic spm_req,
  output logic lpm_req,
  output logic [15:0] z_ptr,
  output logic [15:0] data_pair,
  input wire logic cpu_halt
);
  // Idle bus at time zero.
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_space = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    spm_req = 1'b0;
    lpm_req = 1'b0;
    z_ptr = 16'h0000;
    data_pair = 16'h0000;
  end

  // A halted core issues nothing until the block lets it run again.
  task automatic hold_if_halted();
    while (cpu_halt === 1'b1) @(posedge clk);
  endtask : hold_if_halted

  // Data-space register write; the data lines show garbage once the strobe is gone.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hold_if_halted();
    @(posedge clk);
    io_wr <= 1'b1;
    io_space <= 1'b0;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_wdata <= ~d;
  endtask : wr

  // Register read; data is taken one edge after the strobe edge.
  task automatic rd(input logic [7:0] a, input logic sp, output logic [7:0] d);
    hold_if_halted();
    @(posedge clk);
    io_rd <= 1'b1;
    io_space <= sp;
    io_addr <= a;
    @(posedge clk);
    io_rd <= 1'b0;
    @(posedge clk);
    #1 d = io_rdata;
  endtask : rd

  // Timed sequence: wait until the last store is over, write the command, then store or load.
  task automatic cmd(input logic [7:0] v, input logic [15:0] z, input logic [15:0] d, input logic ld,
                     input int gap);
    logic [7:0] st;
    st = 8'h01;
    // A store enable that never drops is caught by the bench's cycle ceiling.
    while (st[0] !== 1'b0) begin
      rd(8'h57, 1'b0, st);
    end
    wr(8'h57, v);
    repeat (gap) @(posedge clk);
    if (ld) begin
      lpm_req <= 1'b1;
      z_ptr <= z;
    end else begin
      spm_req <= 1'b1;
      z_ptr <= {z[15:1], 1'b0};
      data_pair <= d;
    end
    @(posedge clk);
    spm_req <= 1'b0;
    lpm_req <= 1'b0;
    z_ptr <= ~z_ptr;
    data_pair <= ~data_pair;
  endtask : cmd
endmodule : fspc_core_model
`default_nettype wire

/* tb/tb_flash_self_program_control.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_flash_self_program_control import fspc_pkg::*; ;
  logic clk, rst_b, clk_en, global_ie, io_wr, io_rd, io_space, spm_req, lpm_req;
  logic lpm_hit, cpu_halt, ready_irq, section_busy, erase_go, write_go, lock_go;
  logic [7:0] io_addr, io_wdata, io_rdata, lpm_data, lock_data, st;
  logic [15:0] z_ptr, data_pair, pb_rd_data;
  logic [1:0] boot_size_fuse;
  logic [PC_W-1:0] boot_start;
  logic [PAGE_W-1:0] page_addr;
  logic [WORD_W-1:0] pb_rd_idx;
  logic [4:0] seen;
  int fail_count, num_checks, cyc;
  localparam logic [7:0] LOCKV = 8'h3c;
  localparam logic [7:0] FUSEV = 8'hc5;
  localparam logic [7:0] SIGV = 8'h1e;
  localparam logic [7:0] bad_pat [4] = '{8'h02, 8'h07, 8'h13, 8'h0b};

`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); \
  end \
end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz.
  initial clk = 1'b0;
  always #50 clk = ~clk;

  fspc_ctrl #(.PROG_CNT(8)) dut_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .io_wr(io_wr), .io_rd(io_rd),
    .io_space(io_space), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .spm_req(spm_req),
    .lpm_req(lpm_req), .z_ptr(z_ptr), .data_pair(data_pair), .global_ie(global_ie), .lpm_hit(lpm_hit),
    .lpm_data(lpm_data), .cpu_halt(cpu_halt), .ready_irq(ready_irq), .boot_size_fuse(boot_size_fuse),
    .lock_bits(LOCKV), .fuse_bits(FUSEV), .sig_byte(SIGV), .section_busy(section_busy),
    .boot_start(boot_start), .erase_go(erase_go), .write_go(write_go), .lock_go(lock_go),
    .page_addr(page_addr), .lock_data(lock_data), .pb_rd_idx(pb_rd_idx), .pb_rd_data(pb_rd_data));

  fspc_core_model core_u (.clk(clk), .io_wr(io_wr), .io_rd(io_rd), .io_space(io_space), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .spm_req(spm_req), .lpm_req(lpm_req), .z_ptr(z_ptr),
    .data_pair(data_pair), .cpu_halt(cpu_halt));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic test_done();
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  // Catch one-cycle pulses for later inspection, and cut a hang short.
  always @(posedge clk) begin
    if (erase_go) seen[0] <= 1'b1;
    if (write_go) seen[1] <= 1'b1;
    if (lock_go) seen[2] <= 1'b1;
    if (lpm_hit) seen[3] <= 1'b1;
    if (cpu_halt) seen[4] <= 1'b1;
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end

  // Forget earlier pulses away from the sampling edge.
  task automatic clr();
    @(negedge clk);
    seen = '0;
  endtask : clr

  // Read the control register and compare.
  task automatic chk_rd(input logic [7:0] a, input logic sp, input logic [7:0] e);
    core_u.rd(a, sp, st);
    `CHK("status", e, st)
  endtask : chk_rd

  // Read one page buffer word the way the array does.
  task automatic pbchk(input logic [5:0] i, input logic [15:0] e);
    @(posedge clk);
    pb_rd_idx <= i;
    repeat (2) @(posedge clk);
    #1 `CHK("buffer", e, pb_rd_data)
  endtask : pbchk

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    global_ie = 1'b0;
    boot_size_fuse = 2'h0;
    pb_rd_idx = 6'h00;
    seen = '0;
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    chk_rd(8'h57, 1'b0, SELF_PROGRAM_CONTROL_STATUS_RESET);
    // Boot section start for every fuse code.
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      boot_size_fuse <= i[1:0];
      repeat (2) @(posedge clk);
      #1 `CHK("boot_start", 13'(14'h2000 - (14'h400 >> i)), boot_start)
    end
    // Patterns outside the accepted five leave the register alone.
    for (int i = 0; i < 4; i++) begin
      core_u.wr(8'h57, bad_pat[i]);
      chk_rd(8'h57, 1'b0, 8'h00);
    end
    // Ready interrupt with store enable low, and the I/O-space alias.
    core_u.wr(8'h57, 8'h80);
    global_ie <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("irq", 1'b1, ready_irq)
    chk_rd(8'h37, 1'b1, 8'h80);
    // Erase a shared-region page; pointer top bits set to show they are ignored.
    clr();
    core_u.cmd(8'h83, 16'hc180, 16'h0000, 1'b0, 0);
    chk_rd(8'h57, 1'b0, 8'hc3);
    `CHK("erase", 1'b1, seen[0])
    `CHK("page", 7'h03, page_addr)
    `CHK("irq", 1'b0, ready_irq)
    `CHK("busy", 1'b1, section_busy)
    // Re-enable written while the erase still runs is refused.
    core_u.wr(8'h57, 8'h91);
    chk_rd(8'h57, 1'b0, 8'hc3);
    // Fill on the last cycle of the window clears busy; re-enable discards the buffer.
    core_u.cmd(8'h81, 16'h000a, 16'h1234, 1'b0, 3);
    chk_rd(8'h57, 1'b0, 8'h80);
    pbchk(6'h05, 16'h1234);
    core_u.cmd(8'h91, 16'h0000, 16'h0000, 1'b0, 0);
    pbchk(6'h05, 16'hffff);
    // Page write, word field zero; re-enable once done.
    clr();
    core_u.cmd(8'h85, 16'h0800, 16'h0000, 1'b0, 0);
    chk_rd(8'h57, 1'b0, 8'hc5);
    `CHK("write", 1'b1, seen[1])
    `CHK("page", 7'h10, page_addr)
    core_u.cmd(8'h91, 16'h0000, 16'h0000, 1'b0, 0);
    chk_rd(8'h57, 1'b0, 8'h80);
    // Erase in the top region halts the core and leaves busy low.
    clr();
    core_u.cmd(8'h83, 16'h3f80, 16'h0000, 1'b0, 0);
    repeat (2) @(posedge clk);
    chk_rd(8'h57, 1'b0, 8'h80);
    `CHK("halt", 1'b1, seen[4])
    // Lock programming from the low data byte.
    clr();
    core_u.cmd(8'h89, 16'hffff, 16'h77a5, 1'b0, 0);
    repeat (2) @(posedge clk);
    #1 `CHK("lock", 1'b1, seen[2])
    `CHK("lock_data", 8'ha5, lock_data)
    // Lock, fuse and signature readback.
    core_u.cmd(8'h89, 16'h0000, 16'h0000, 1'b1, 0);
    repeat (2) @(posedge clk);
    #1 `CHK("lpm", LOCKV, lpm_data)
    core_u.cmd(8'h89, 16'h0001, 16'h0000, 1'b1, 2);
    repeat (2) @(posedge clk);
    #1 `CHK("lpm", FUSEV, lpm_data)
    clr();
    core_u.cmd(8'ha1, 16'h0000, 16'h0000, 1'b1, 0);
    repeat (2) @(posedge clk);
    #1 `CHK("lpm", SIGV, lpm_data)
    `CHK("hit", 1'b1, seen[3])
    // A store after the signature command does nothing.
    clr();
    core_u.cmd(8'ha1, 16'h0002, 16'h5555, 1'b0, 0);
    pbchk(6'h01, 16'hffff);
    `CHK("go", 3'h0, seen[2:0])
    // A store one cycle past the window is refused and the command lapses.
    core_u.cmd(8'h83, 16'h0180, 16'h0000, 1'b0, 4);
    repeat (2) @(posedge clk);
    #1 `CHK("erase", 1'b0, seen[0])
    chk_rd(8'h57, 1'b0, 8'h80);
    // A low clock enable holds the interrupt request; it drops once the enable returns.
    @(posedge clk);
    clk_en <= 1'b0;
    global_ie <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK("frozen_irq", 1'b1, ready_irq)
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("irq", 1'b0, ready_irq)
    test_done();
  end
endmodule : tb_flash_self_program_control
`default_nettype wire
